// [core/rfic_pkg.sv]
`default_nettype none
package rfic_pkg;

    // reset causes presented by the reset controller
    typedef enum logic [2:0] {
        RST_NONE     = 3'b000,
        RST_SOFTWARE = 3'b001,
        RST_WATCHDOG = 3'b010,
        RST_SHORT_HW = 3'b011,
        RST_LONG_HW  = 3'b100,
        RST_ASYNC_HW = 3'b101,
        RST_POWER_ON = 3'b110
    } rfic_cause_t;

    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_DRAIN = 2'b01,
        PWR_IDLE  = 2'b10,
        PWR_DOWN  = 2'b11
    } rfic_pstate_t;

    typedef struct packed {
        logic power_on;
        logic long_hw;
        logic short_hw;
        logic software;
        logic watchdog;
    } rfic_flags_t;

    // register offsets
    localparam logic [3:0] ADDR_FLAGS   = 4'h0;
    localparam logic [3:0] ADDR_PORTCFG = 4'h1;
    localparam logic [3:0] ADDR_SYSCFG  = 4'h2;
    localparam logic [3:0] ADDR_BUSCFG  = 4'h3;
    localparam logic [3:0] ADDR_IRQ_ST  = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h5;
    localparam logic [3:0] ADDR_PSTATE  = 4'h6;

    // which config port bits are resampled per reset type
    localparam logic [15:0] MASK_SW_WDT  = 16'h1fc0;
    localparam logic [15:0] MASK_SHORT   = 16'h1fff;
    localparam logic [15:0] MASK_FULL    = 16'hffff;
    localparam logic [15:0] CFG_RST_VAL  = 16'h0000;

    // irq status bit positions
    localparam int IRQ_RESET = 0;
    localparam int IRQ_IDLE  = 1;
    localparam int IRQ_WAKE  = 2;
    localparam int IRQ_REFUSE = 3;
    localparam int IRQ_W     = 4;

endpackage
`default_nettype wire

// [core/rfic_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module rfic_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // rfic_sync2
`default_nettype wire

// [core/rfic_cfg_sampler.sv]
`timescale 1ns/10ps
`default_nettype none
module rfic_cfg_sampler (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // capture request
    input  wire logic                  capture,
    input  wire rfic_pkg::rfic_cause_t cause,
    input  wire logic [15:0]           port_pins,
    // latched configuration
    output logic      [15:0]           cfg
);
    function automatic logic [15:0] sample_mask(input rfic_pkg::rfic_cause_t c);
        case (c)
            rfic_pkg::RST_SOFTWARE,
            rfic_pkg::RST_WATCHDOG: sample_mask = rfic_pkg::MASK_SW_WDT;
            rfic_pkg::RST_SHORT_HW: sample_mask = rfic_pkg::MASK_SHORT;
            rfic_pkg::RST_LONG_HW,
            rfic_pkg::RST_ASYNC_HW,
            rfic_pkg::RST_POWER_ON: sample_mask = rfic_pkg::MASK_FULL;
            default:                sample_mask = 16'h0000;
        endcase
    endfunction

    logic [15:0] m;
    assign m = sample_mask(cause);

    // unsampled bits keep the value from the previous reset
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            cfg <= rfic_pkg::CFG_RST_VAL;
        else if (capture)
            cfg <= (cfg & ~m) | (port_pins & m);
    end

    AST_SW_KEEP_CLK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture && cause == rfic_pkg::RST_SOFTWARE |=> cfg[15:13] == $past(cfg[15:13]) && cfg[5:0] == $past(cfg[5:0]))
        else $error("software reset changed unsampled config bits");
    AST_SHORT_KEEP_CLK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture && cause == rfic_pkg::RST_SHORT_HW |=> cfg == {$past(cfg[15:13]), $past(port_pins[12:0])})
        else $error("short reset config capture wrong");
    AST_FULL_SAMPLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture && (cause == rfic_pkg::RST_POWER_ON || cause == rfic_pkg::RST_LONG_HW) |=> cfg == $past(port_pins))
        else $error("full config capture wrong");
endmodule // rfic_cfg_sampler
`default_nettype wire

// [core/rfic_top.sv]
//Contract
//- software reset sets only the software flag.
//- bidirectional sw/wdt reset with delay input low may chain short hw reset.
//- prolonged short hardware reset is flagged as long hardware reset.
//- after reset, sampled port bits go to port, system and bus config.
//- sw/wdt reset samples high bits 4..0 and low bits 7..6 only.
//- short hw reset samples all bits except high bits 7..5.
//- long, async and power-on resets sample all sixteen bits.
//- idle stops the cpu, peripherals keep running.
//- power-down stops cpu and peripherals.
//- idle and power-down entered only via protected instructions.
//- pending external bus cycles finish before entry.
//- entry refused if ready enabled but never seen on last access.
//- any interrupt request ends idle.
//- after idle the next instruction runs after interrupt return.
`timescale 1ns/10ps
`default_nettype none
module rfic_top #(
    parameter int PROLONG_CYCLES = 16
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // reset controller
    input  wire logic        reset_event,
    input  wire logic [2:0]  reset_cause,
    input  wire logic        reset_bidir,
    input  wire logic        reset_delay_input,
    input  wire logic        short_reset_held,
    input  wire logic [15:0] config_port,
    // cpu and bus
    input  wire logic        idle_instr,
    input  wire logic        power_down_instruction,
    input  wire logic        bus_busy,
    input  wire logic        ready_enable,
    input  wire logic        ready_polarity,
    input  wire logic        ready_pin,
    input  wire logic        bus_access_start,
    input  wire logic        irq_request,
    input  wire logic        interrupt_return_instruction,
    // control outputs
    output logic             cpu_stop,
    output logic             periph_stop,
    output logic             chain_short_reset,
    output logic             resume_after_idle,
    output logic             irq,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata
);
    rfic_pkg::rfic_flags_t  flags;
    rfic_pkg::rfic_pstate_t pstate;
    rfic_pkg::rfic_pstate_t next_pstate;
    rfic_pkg::rfic_cause_t  cause_eff;
    logic [15:0] port_cfg;
    logic [15:0] sys_cfg;
    logic [15:0] bus_cfg;
    logic [15:0] pins_sync;
    logic [2:0]  async_sync;
    logic        rdel_s;
    logic        ready_s;
    logic        rheld_s;
    logic        ready_seen;
    logic        pend_pd;
    logic        idle_wake;
    logic [rfic_pkg::IRQ_W-1:0] irq_st;
    logic [rfic_pkg::IRQ_W-1:0] irq_msk;
    logic [rfic_pkg::IRQ_W-1:0] irq_set;
    logic        refuse;
    logic [$clog2(PROLONG_CYCLES+1)-1:0] held_cnt;
    logic        prolonged;

    // pins and the reset delay line come from outside the clock domain
    rfic_sync2 #(.WIDTH(16)) u_sync_pins (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (config_port),
        .sync_out (pins_sync)
    );
    rfic_sync2 #(.WIDTH(3)) u_sync_ctl (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in ({reset_delay_input, ready_pin, short_reset_held}),
        .sync_out (async_sync)
    );
    assign rdel_s  = async_sync[2];
    assign ready_s = async_sync[1];
    assign rheld_s = async_sync[0];

    // short reset held too long is promoted
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            held_cnt <= '0;
        else if (!rheld_s)
            held_cnt <= '0;
        else if (!prolonged)
            held_cnt <= held_cnt + 1'b1;
    end
    assign prolonged = (held_cnt == ($clog2(PROLONG_CYCLES+1))'(PROLONG_CYCLES));

    always_comb
    begin
        cause_eff = rfic_pkg::rfic_cause_t'(reset_cause);
        if (cause_eff == rfic_pkg::RST_SHORT_HW && prolonged)
            cause_eff = rfic_pkg::RST_LONG_HW;
    end

    // reset flags
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            flags <= '0;
        else if (reset_event)
        begin
            case (cause_eff)
                rfic_pkg::RST_SOFTWARE: flags <= 5'b00010;
                rfic_pkg::RST_WATCHDOG: flags <= 5'b00011;
                rfic_pkg::RST_SHORT_HW: flags <= 5'b00110;
                rfic_pkg::RST_LONG_HW,
                rfic_pkg::RST_ASYNC_HW: flags <= 5'b01110;
                rfic_pkg::RST_POWER_ON: flags <= 5'b11110;
                default:                flags <= flags;
            endcase
        end
    end

    // chain short reset after bidirectional sw/wdt reset
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            chain_short_reset <= 1'b0;
        else
            chain_short_reset <= reset_event && reset_bidir && !rdel_s
                && (cause_eff == rfic_pkg::RST_SOFTWARE || cause_eff == rfic_pkg::RST_WATCHDOG);
    end

    // one sampler per config register; same mask per reset type
    rfic_cfg_sampler u_port_cfg (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .capture   (reset_event),
        .cause     (cause_eff),
        .port_pins (pins_sync),
        .cfg       (port_cfg)
    );
    rfic_cfg_sampler u_sys_cfg (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .capture   (reset_event),
        .cause     (cause_eff),
        .port_pins (pins_sync),
        .cfg       (sys_cfg)
    );
    rfic_cfg_sampler u_bus_cfg (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .capture   (reset_event),
        .cause     (cause_eff),
        .port_pins (pins_sync),
        .cfg       (bus_cfg)
    );

    // ready seen during last bus access
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ready_seen <= 1'b1;
        else if (bus_access_start)
            ready_seen <= 1'b0;
        else if (ready_s == ready_polarity)
            ready_seen <= 1'b1;
    end
    assign refuse = ready_enable && !ready_seen;

    // power state machine
    always_comb
    begin
        next_pstate = pstate;
        case (pstate)
            rfic_pkg::PWR_RUN:
                if (idle_instr || power_down_instruction)
                    next_pstate = rfic_pkg::PWR_DRAIN;
            rfic_pkg::PWR_DRAIN:
                if (refuse)
                    next_pstate = rfic_pkg::PWR_RUN;
                else if (!bus_busy)
                    next_pstate = pend_pd ? rfic_pkg::PWR_DOWN : rfic_pkg::PWR_IDLE;
            rfic_pkg::PWR_IDLE:
                if (irq_request)
                    next_pstate = rfic_pkg::PWR_RUN;
            rfic_pkg::PWR_DOWN:
                next_pstate = rfic_pkg::PWR_DOWN; // left only by reset
            default:
                next_pstate = rfic_pkg::PWR_RUN;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || reset_event)
            pstate <= rfic_pkg::PWR_RUN;
        else
            pstate <= next_pstate;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pend_pd <= 1'b0;
        else if (pstate == rfic_pkg::PWR_RUN && (idle_instr || power_down_instruction))
            pend_pd <= power_down_instruction;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cpu_stop    <= 1'b0;
            periph_stop <= 1'b0;
        end
        else
        begin
            // a reset event forces run, so the stop outputs must not follow the stale next state
            cpu_stop    <= !reset_event
                && (next_pstate == rfic_pkg::PWR_IDLE || next_pstate == rfic_pkg::PWR_DOWN);
            periph_stop <= !reset_event && next_pstate == rfic_pkg::PWR_DOWN;
        end
    end

    // after idle wake, resume at following instruction once interrupt_return_instruction retires
    assign idle_wake = pstate == rfic_pkg::PWR_IDLE && irq_request;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            resume_after_idle <= 1'b0;
        else if (idle_wake)
            resume_after_idle <= 1'b1;
        else if (interrupt_return_instruction)
            resume_after_idle <= 1'b0;
    end

    // sticky interrupt status, write one to clear, set wins
    always_comb
    begin
        irq_set = '0;
        irq_set[rfic_pkg::IRQ_RESET]  = reset_event;
        irq_set[rfic_pkg::IRQ_IDLE]   = pstate != rfic_pkg::PWR_IDLE && next_pstate == rfic_pkg::PWR_IDLE;
        irq_set[rfic_pkg::IRQ_WAKE]   = idle_wake;
        irq_set[rfic_pkg::IRQ_REFUSE] = pstate == rfic_pkg::PWR_DRAIN && refuse;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_st <= '0;
        else if (reg_wr && reg_addr == rfic_pkg::ADDR_IRQ_ST)
            irq_st <= (irq_st & ~reg_wdata[rfic_pkg::IRQ_W-1:0]) | irq_set;
        else
            irq_st <= irq_st | irq_set;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_msk <= '0;
        else if (reg_wr && reg_addr == rfic_pkg::ADDR_IRQ_MSK)
            irq_msk <= reg_wdata[rfic_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |((irq_st | irq_set) & irq_msk);
    end

    // register read, unmapped reads zero
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                rfic_pkg::ADDR_FLAGS:   reg_rdata <= {11'h0, flags};
                rfic_pkg::ADDR_PORTCFG: reg_rdata <= port_cfg;
                rfic_pkg::ADDR_SYSCFG:  reg_rdata <= sys_cfg;
                rfic_pkg::ADDR_BUSCFG:  reg_rdata <= bus_cfg;
                rfic_pkg::ADDR_IRQ_ST:  reg_rdata <= {12'h000, irq_st};
                rfic_pkg::ADDR_IRQ_MSK: reg_rdata <= {12'h000, irq_msk};
                rfic_pkg::ADDR_PSTATE:  reg_rdata <= {14'h0, pstate};
                default:                reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    sequence s_sw_reset;
        reset_event && cause_eff == rfic_pkg::RST_SOFTWARE;
    endsequence
    sequence s_wdt_reset;
        reset_event && cause_eff == rfic_pkg::RST_WATCHDOG;
    endsequence

    AST_SW_FLAGS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_sw_reset |=> flags == 5'b00010)
        else $error("software reset flags wrong");
    AST_WDT_FLAGS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_wdt_reset |=> flags == 5'b00011)
        else $error("watchdog reset flags wrong");
    AST_CHAIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        chain_short_reset |-> $past(reset_bidir) && !$past(rdel_s))
        else $error("chained reset without bidir and delay low");
    AST_PROLONG: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reset_event && reset_cause == rfic_pkg::RST_SHORT_HW && prolonged |=> flags.long_hw)
        else $error("prolonged short reset not flagged long");
    AST_CFG_SAME: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reset_event |=> port_cfg == sys_cfg && sys_cfg == bus_cfg)
        else $error("config registers diverge");
    AST_IDLE_PERIPH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pstate == rfic_pkg::PWR_IDLE |-> cpu_stop && !periph_stop)
        else $error("idle state stops peripherals");
    AST_PD_STOP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pstate == rfic_pkg::PWR_DOWN |-> cpu_stop && periph_stop)
        else $error("power down not stopping all");
    AST_NO_SPONT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(pstate == rfic_pkg::PWR_DRAIN) |-> $past(idle_instr || power_down_instruction))
        else $error("entry without instruction");
    AST_BUS_DONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pstate == rfic_pkg::PWR_DRAIN && bus_busy && !refuse && !reset_event |=> pstate == rfic_pkg::PWR_DRAIN)
        else $error("entered with bus busy");
    AST_REFUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pstate == rfic_pkg::PWR_DRAIN && refuse |=> pstate == rfic_pkg::PWR_RUN)
        else $error("entry not refused");
    AST_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        idle_wake |=> pstate == rfic_pkg::PWR_RUN ##1 !cpu_stop)
        else $error("interrupt did not end idle");
    AST_RESUME: assert property (@(posedge ref_clk) disable iff (sys_rst)
        idle_wake |=> resume_after_idle)
        else $error("resume flag not set after idle");
endmodule // rfic_top
`default_nettype wire

// [test/rfic_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rfic_bus_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // command from the bench
    input  wire logic       bm_go,
    input  wire logic       bm_ok,
    input  wire logic [3:0] bm_len,
    input  wire logic       ready_polarity,
    // external bus side
    output logic            bus_busy,
    output logic            bus_access_start,
    output logic            ready_pin
);
    logic [3:0] left;

    // ready falls back to its inactive level outside an access, never a stale active one
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            left             <= 4'h0;
            bus_busy         <= 1'b0;
            bus_access_start <= 1'b0;
            ready_pin        <= 1'b1;
        end
        else
        begin
            bus_access_start <= bm_go;
            left             <= bm_go ? bm_len : ((left != 4'h0) ? left - 4'h1 : 4'h0);
            bus_busy         <= bm_go || (left > 4'h1);
            ready_pin        <= (bm_ok && (bm_go || left != 4'h0)) ? ready_polarity : ~ready_polarity;
        end
    end
endmodule // rfic_bus_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        ref_clk, sys_rst, reset_event, reset_bidir, reset_delay_input, short_reset_held;
    logic        idle_instr, power_down_instruction, bus_busy, ready_enable, ready_polarity, ready_pin;
    logic        bus_access_start, irq_request, interrupt_return_instruction, cpu_stop, periph_stop;
    logic        chain_short_reset, resume_after_idle, irq, reg_wr, reg_rd, bm_go, bm_ok;
    logic [2:0]  reset_cause;
    logic [3:0]  reg_addr, bm_len;
    logic [15:0] config_port, reg_wdata, reg_rdata, exp_cfg, d;
    int          err_total, n_checks, cyc, chains;

    rfic_top #(.PROLONG_CYCLES(4)) i_dut (
        .ref_clk, .sys_rst, .reset_event, .reset_cause, .reset_bidir, .reset_delay_input, .short_reset_held,
        .config_port, .idle_instr, .power_down_instruction, .bus_busy, .ready_enable, .ready_polarity,
        .ready_pin, .bus_access_start, .irq_request, .interrupt_return_instruction, .cpu_stop, .periph_stop,
        .chain_short_reset, .resume_after_idle, .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );
    rfic_bus_model i_bus (.ref_clk, .sys_rst, .bm_go, .bm_ok, .bm_len, .ready_polarity, .bus_busy,
        .bus_access_start, .ready_pin);

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (chain_short_reset === 1'b1)
            chains++;
        // whole run needs about 500 cycles
        if (cyc == 6000)
        begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_stop(input logic want);
        int i;
        i = 0;
        while (cpu_stop !== want && i < 20)
        begin
            @(posedge ref_clk);
            #1 i++;
        end
    endtask

    task automatic instr(input logic pd);
        @(posedge ref_clk);
        if (pd)
            power_down_instruction <= 1'b1;
        else
            idle_instr <= 1'b1;
        @(posedge ref_clk);
        power_down_instruction <= 1'b0;
        idle_instr <= 1'b0;
    endtask

    task automatic wake();
        @(posedge ref_clk);
        irq_request <= 1'b1;
        @(posedge ref_clk);
        irq_request <= 1'b0;
        wait_stop(1'b0);
        chk(cpu_stop, 1'b0);
        chk(resume_after_idle, 1'b1);
        @(posedge ref_clk);
        interrupt_return_instruction <= 1'b1;
        @(posedge ref_clk);
        interrupt_return_instruction <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk(resume_after_idle, 1'b0);
    endtask

    // pins settle well before the event so the synchronisers have them
    task automatic do_rst(input logic [2:0] c, input logic [15:0] p, input logic bd, input logic dl,
                          input logic hd);
        logic [15:0] m;
        m = (c == 3'h1 || c == 3'h2) ? 16'h1fc0 : ((c == 3'h3 && !hd) ? 16'h1fff : 16'hffff);
        exp_cfg = (exp_cfg & ~m) | (p & m);
        @(posedge ref_clk);
        config_port <= p;
        reset_bidir <= bd;
        reset_delay_input <= dl;
        short_reset_held <= hd;
        repeat (8) @(posedge ref_clk);
        reset_event <= 1'b1;
        reset_cause <= c;
        @(posedge ref_clk);
        reset_event <= 1'b0;
        repeat (8) @(posedge ref_clk);
        short_reset_held <= 1'b0;
        for (int a = 1; a < 4; a++)
        begin
            rd(4'(a));
            chk(d, exp_cfg);
        end
    endtask

    task automatic t_resets();
        logic [2:0]  cs [6] = '{3'h6, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
        logic [15:0] ps [6] = '{16'ha5c3, 16'h5a3c, 16'h0ff0, 16'hf00f, 16'h3cc3, 16'hc33c};
        logic [4:0]  fl [6] = '{5'h00, 5'h02, 5'h03, 5'h06, 5'h0e, 5'h0e};
        for (int i = 0; i < 6; i++)
        begin
            do_rst(cs[i], ps[i], 1'b0, 1'b1, 1'b0);
            rd(4'h0);
            if (i > 0)
                chk(d, {11'h0, fl[i]});
        end
        $display("test resets done");
    endtask

    task automatic t_chain();
        int c0;
        c0 = chains;
        do_rst(3'h1, 16'h1234, 1'b1, 1'b0, 1'b0);
        chk(16'(chains - c0), 16'h1);
        c0 = chains;
        do_rst(3'h2, 16'h4321, 1'b1, 1'b1, 1'b0);
        do_rst(3'h1, 16'h9876, 1'b0, 1'b0, 1'b0);
        chk(16'(chains - c0), 16'h0);
        do_rst(3'h3, 16'hbeef, 1'b0, 1'b1, 1'b1);
        rd(4'h0);
        chk(d, 16'h000e);
        $display("test chain and prolong done");
    endtask

    task automatic t_irq();
        // a mask bit of one enables its status bit onto the interrupt line
        wr(4'h5, 16'h0000);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b0);
        wr(4'h5, 16'h000f);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b1);
        wr(4'h4, 16'h000f);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b0);
        rd(4'h4);
        chk(d, 16'h0000);
        rd(4'hf);
        chk(d, 16'h0000);
        // flags are read-only
        wr(4'h0, 16'hffff);
        rd(4'h0);
        chk(d, 16'h000e);
        $display("test irq done");
    endtask

    task automatic t_idle();
        repeat (10) @(posedge ref_clk);
        #1 chk(cpu_stop, 1'b0);
        instr(1'b0);
        wait_stop(1'b1);
        chk(cpu_stop, 1'b1);
        chk(periph_stop, 1'b0);
        rd(4'h6);
        chk(d, 16'h0002);
        wake();
        rd(4'h4);
        chk(d & 16'h0006, 16'h0006);
        $display("test idle done");
    endtask

    task automatic t_drain();
        @(posedge ref_clk);
        bm_ok <= 1'b1;
        bm_len <= 4'h8;
        bm_go <= 1'b1;
        @(posedge ref_clk);
        bm_go <= 1'b0;
        idle_instr <= 1'b1;
        @(posedge ref_clk);
        idle_instr <= 1'b0;
        #1;
        while (bus_busy === 1'b1)
        begin
            chk(cpu_stop, 1'b0);
            @(posedge ref_clk);
            #1;
        end
        wait_stop(1'b1);
        chk(cpu_stop, 1'b1);
        wake();
        $display("test drain done");
    endtask

    task automatic t_refuse();
        for (int pol = 0; pol < 2; pol++)
        begin
            @(posedge ref_clk);
            ready_enable <= 1'b1;
            ready_polarity <= pol[0];
            for (int ok = 0; ok < 2; ok++)
            begin
                @(posedge ref_clk);
                bm_ok <= ok[0];
                bm_len <= 4'h6;
                bm_go <= 1'b1;
                @(posedge ref_clk);
                bm_go <= 1'b0;
                repeat (12) @(posedge ref_clk);
                instr(1'b0);
                repeat (10) @(posedge ref_clk);
                #1 chk(cpu_stop, 16'(ok));
                if (ok == 0)
                begin
                    rd(4'h4);
                    chk(d & 16'h0008, 16'h0008);
                    wr(4'h4, 16'h0008);
                end
                else
                    wake();
            end
        end
        @(posedge ref_clk);
        ready_enable <= 1'b0;
        $display("test refuse done");
    endtask

    task automatic t_pdown();
        instr(1'b1);
        wait_stop(1'b1);
        chk(cpu_stop, 1'b1);
        chk(periph_stop, 1'b1);
        @(posedge ref_clk);
        irq_request <= 1'b1;
        @(posedge ref_clk);
        irq_request <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 chk({cpu_stop, periph_stop}, 16'h3);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk({cpu_stop, periph_stop}, 16'h0);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        $display("test power down done");
    endtask

    initial
    begin
        {reset_event, reset_bidir, reset_delay_input, short_reset_held, idle_instr, power_down_instruction,
         ready_enable, ready_polarity, irq_request, interrupt_return_instruction, reg_wr, reg_rd, bm_go,
         bm_ok, reset_cause, reg_addr, bm_len, config_port, reg_wdata, exp_cfg} = '0;
        sys_rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_resets();
        t_chain();
        t_irq();
        t_idle();
        t_drain();
        t_refuse();
        t_pdown();
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
